//--- hdl/p23io_pkg.sv
// Package of offsets, field positions, reset values and carrier types for the port logic
package p23io_pkg;

	// Register byte offsets on the register bus
	localparam logic [7:0] OFS_DATA = 8'h00;
	localparam logic [7:0] OFS_BIDIR_MODE = 8'h04;
	localparam logic [7:0] OFS_INPORT_MODE = 8'h08;
	localparam logic [7:0] OFS_EDGE_CFG = 8'h0C;
	localparam logic [7:0] OFS_INT_STATUS = 8'h10;
	localparam logic [7:0] OFS_INT_CLEAR = 8'h14;
	localparam logic [7:0] OFS_INT_ENABLE = 8'h18;
	localparam logic [7:0] OFS_LEVELS = 8'h1C;

	// Reset values
	localparam logic [7:0] BIDIR_MODE_RST = 8'hFF;
	localparam logic [7:0] INPORT_MODE_RST = 8'h00;
	localparam logic [6:0] EDGE_CFG_RST = 7'h00;
	localparam logic [2:0] INT_RST = 3'h0;

	// Input-port mode fields
	localparam int INM_PUSHPULL = 0;
	localparam int INM_CMP_EN = 1;

	// Interrupt status bit positions
	localparam int ST_PIN1 = 0;
	localparam int ST_PIN2 = 1;
	localparam int ST_WAKE = 2;
	localparam int ST_W = 3;

	// Edge trigger encodings
	localparam logic [1:0] EDGE_OFF = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;

	// Pipeline depth from pin to synchronised level
	localparam int SYNC_STAGES = 2;
	localparam logic [1:0] SETTLE_CNT = 2'h3;

	// Edge, timer source and wake configuration, register bits 6..0
	typedef struct packed {
		logic wakeEn;
		logic wakeSelAnd;
		logic timerSelBidir;
		logic [1:0] pin2Edge;
		logic [1:0] pin1Edge;
	} p23io_edgecfg_t;

	// Synchronised input-port levels
	typedef struct packed {
		logic pin2;
		logic pin1;
	} p23io_inlvl_t;

	// Register bus slave states
	typedef enum logic {
		BUS_IDLE,
		BUS_RDWAIT
	} p23io_bus_t;

endpackage

//--- hdl/p23io_sync.sv
// Two-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ns
`default_nettype none

module p23io_sync #(
	parameter int WIDTH = 1
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge core_clk) begin
		if (reset) begin
			meta_q <= '0;
			syncOut <= '0;
		end else begin
			meta_q <= asyncIn;
			syncOut <= meta_q;
		end
	end

endmodule
`default_nettype wire

//--- hdl/p23io_port.sv
// Bidirectional port, input-port edge interrupts, wake gates and timer edge source
`timescale 1ns/1ns
`default_nettype none

module p23io_port #(
	parameter int PORT_W = 8
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic stopRecover,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [PORT_W-1:0] bidirIn,
	output logic [PORT_W-1:0] bidirOut,
	output logic [PORT_W-1:0] bidirOe_n,
	input wire logic inportPin1,
	input wire logic inportPin2,
	input wire logic [1:0] cmpOut,
	output logic cmpEnable,
	input wire logic timerDemodMode,
	output logic timerEdgeIn,
	output logic wakeOrLevel,
	output logic wakeAndLevel,
	output logic wakeRequest,
	output logic [1:0] irqRequest,
	output logic irqOut
);

	// Registers are one word each, so the port cannot exceed the data width
	if (PORT_W < 1 || PORT_W > 32) begin : g_chk
		$error("PORT_W must lie between 1 and 32");
	end

	localparam int SW = PORT_W + 4;

	logic [PORT_W-1:0] dataReg_q;
	logic [PORT_W-1:0] modeReg_q;
	logic [7:0] inMode_q;
	p23io_pkg::p23io_edgecfg_t edgeCfg_q;
	logic [p23io_pkg::ST_W-1:0] status_q;
	logic [p23io_pkg::ST_W-1:0] enable_q;
	logic [p23io_pkg::ST_W-1:0] statusSet;
	logic [SW-1:0] syncd;
	logic [PORT_W-1:0] bidirLvl;
	p23io_pkg::p23io_inlvl_t inLvl;
	p23io_pkg::p23io_inlvl_t inPrev_q;
	logic wakePrev_q;
	logic pin1Hit;
	logic pin2Hit;
	p23io_pkg::p23io_bus_t busState_q;
	logic [7:0] rdAddr_q;
	logic [7:0] wrAddr_q;
	logic wrPend_q;
	logic addrPhase;
	logic [31:0] rdMux;
	logic [1:0] upCnt_q;
	logic settled;

	// Trigger test shared by both interrupt pins
	function automatic logic edgeHit(input logic [1:0] mode, input logic cur, input logic prev);
		logic hit;
		hit = 1'b0;
		case (mode)
			p23io_pkg::EDGE_RISE: hit = cur & ~prev;
			p23io_pkg::EDGE_FALL: hit = ~cur & prev;
			p23io_pkg::EDGE_BOTH: hit = cur ^ prev;
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction

	p23io_sync #(
		.WIDTH(SW)
	) u_sync (
		.core_clk(core_clk),
		.reset(reset),
		.asyncIn({cmpOut, inportPin2, inportPin1, bidirIn}),
		.syncOut(syncd)
	);

	assign bidirLvl = syncd[PORT_W-1:0];
	assign cmpEnable = inMode_q[p23io_pkg::INM_CMP_EN];

	always_comb begin
		inLvl.pin1 = cmpEnable ? syncd[PORT_W+2] : syncd[PORT_W];
		inLvl.pin2 = cmpEnable ? syncd[PORT_W+3] : syncd[PORT_W+1];
	end

	// Register bus: writes take no wait, reads one wait so a prior write is seen
	assign addrPhase = hsel && hready && htrans[1];
	assign hreadyout = (busState_q != p23io_pkg::BUS_RDWAIT);
	assign hresp = 1'b0;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			busState_q <= p23io_pkg::BUS_IDLE;
			rdAddr_q <= 8'h00;
			wrAddr_q <= 8'h00;
			wrPend_q <= 1'b0;
		end else begin
			wrPend_q <= addrPhase && hwrite;
			if (addrPhase) begin
				rdAddr_q <= haddr[7:0];
				wrAddr_q <= haddr[7:0];
			end
			unique case (busState_q)
				p23io_pkg::BUS_IDLE: begin
					if (addrPhase && !hwrite) begin
						busState_q <= p23io_pkg::BUS_RDWAIT;
					end
				end
				p23io_pkg::BUS_RDWAIT: begin
					busState_q <= p23io_pkg::BUS_IDLE;
				end
			endcase
		end
	end

	// Read map; unmapped and write-only offsets read zero
	always_comb begin
		rdMux = 32'h0000_0000;
		case (rdAddr_q)
			p23io_pkg::OFS_DATA: rdMux[PORT_W-1:0] = bidirLvl;
			p23io_pkg::OFS_BIDIR_MODE: rdMux[PORT_W-1:0] = modeReg_q;
			p23io_pkg::OFS_INPORT_MODE: rdMux[7:0] = inMode_q;
			p23io_pkg::OFS_EDGE_CFG: rdMux[6:0] = edgeCfg_q;
			p23io_pkg::OFS_INT_STATUS: rdMux[p23io_pkg::ST_W-1:0] = status_q;
			p23io_pkg::OFS_INT_ENABLE: rdMux[p23io_pkg::ST_W-1:0] = enable_q;
			p23io_pkg::OFS_LEVELS: rdMux[3:0] = {syncd[PORT_W+3:PORT_W+2], inLvl};
			default: rdMux = 32'h0000_0000;
		endcase
	end

	// Read data captured during the wait cycle
	always_ff @(posedge core_clk) begin
		if (reset) begin
			hrdata <= 32'h0000_0000;
		end else if (busState_q == p23io_pkg::BUS_RDWAIT) begin
			hrdata <= rdMux;
		end
	end

	// mode registers reset by power-on only
	always_ff @(posedge core_clk) begin
		if (reset) begin
			modeReg_q <= '1;
			inMode_q <= p23io_pkg::INPORT_MODE_RST;
		end else if (wrPend_q) begin
			if (wrAddr_q == p23io_pkg::OFS_BIDIR_MODE) begin
				modeReg_q <= hwdata[PORT_W-1:0];
			end
			if (wrAddr_q == p23io_pkg::OFS_INPORT_MODE) begin
				inMode_q <= hwdata[7:0];
			end
		end
	end

	// data register software owned, also cleared on stop recovery
	// Other control state returns to reset values on stop recovery
	always_ff @(posedge core_clk) begin
		if (reset || stopRecover) begin
			dataReg_q <= '0;
			edgeCfg_q <= p23io_pkg::EDGE_CFG_RST;
			enable_q <= p23io_pkg::INT_RST;
		end else if (wrPend_q) begin
			if (wrAddr_q == p23io_pkg::OFS_DATA) begin
				dataReg_q <= hwdata[PORT_W-1:0];
			end
			if (wrAddr_q == p23io_pkg::OFS_EDGE_CFG) begin
				edgeCfg_q <= hwdata[6:0];
			end
			if (wrAddr_q == p23io_pkg::OFS_INT_ENABLE) begin
				enable_q <= hwdata[p23io_pkg::ST_W-1:0];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			bidirOut <= '0;
			bidirOe_n <= '1;
		end else if (inMode_q[p23io_pkg::INM_PUSHPULL]) begin
			bidirOut <= dataReg_q;
			bidirOe_n <= modeReg_q;
		end else begin
			bidirOut <= '0;
			bidirOe_n <= modeReg_q | dataReg_q; // Open drain: a one releases the line
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			wakeOrLevel <= 1'b0;
			wakeAndLevel <= 1'b0;
			wakeRequest <= 1'b0;
			wakePrev_q <= 1'b0;
		end else begin
			wakeOrLevel <= |bidirLvl;
			wakeAndLevel <= &bidirLvl;
			wakeRequest <= edgeCfg_q.wakeEn & (edgeCfg_q.wakeSelAnd ? wakeAndLevel : wakeOrLevel);
			wakePrev_q <= wakeRequest;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			timerEdgeIn <= 1'b0;
		end else if (edgeCfg_q.timerSelBidir && timerDemodMode) begin
			timerEdgeIn <= bidirLvl[0];
		end else begin
			timerEdgeIn <= inLvl.pin1;
		end
	end

	// edge triggers for pins 1 and 2
	assign pin1Hit = edgeHit(edgeCfg_q.pin1Edge, inLvl.pin1, inPrev_q.pin1);
	assign pin2Hit = edgeHit(edgeCfg_q.pin2Edge, inLvl.pin2, inPrev_q.pin2);
	assign statusSet = {wakeRequest & ~wakePrev_q, pin2Hit, pin1Hit};

	always_ff @(posedge core_clk) begin
		if (reset) begin
			inPrev_q <= '0;
			irqRequest <= 2'h0;
		end else begin
			inPrev_q <= inLvl;
			irqRequest <= {pin2Hit, pin1Hit};
		end
	end

	// Sticky status; a new event beats a same-cycle clear
	always_ff @(posedge core_clk) begin
		if (reset || stopRecover) begin
			status_q <= p23io_pkg::INT_RST;
		end else if (wrPend_q && wrAddr_q == p23io_pkg::OFS_INT_CLEAR) begin
			status_q <= (status_q & ~hwdata[p23io_pkg::ST_W-1:0]) | statusSet;
		end else begin
			status_q <= status_q | statusSet;
		end
	end

	assign irqOut = |(status_q & enable_q);

	// Helper for assertions: pipeline filled since reset
	always_ff @(posedge core_clk) begin
		if (reset) begin
			upCnt_q <= 2'h0;
		end else if (upCnt_q != p23io_pkg::SETTLE_CNT) begin
			upCnt_q <= upCnt_q + 2'h1;
		end
	end
	assign settled = (upCnt_q == p23io_pkg::SETTLE_CNT);

	property p_por_inputs;
		@(posedge core_clk) reset ##1 reset |=> bidirOe_n == '1;
	endproperty
	a_por_inputs: assert property (p_por_inputs) else $error("lines not inputs after reset");

	property p_dir_bits;
		@(posedge core_clk) disable iff (reset)
		settled |-> (bidirOe_n & $past(modeReg_q)) == $past(modeReg_q);
	endproperty
	a_dir_bits: assert property (p_dir_bits) else $error("input line is driven");

	property p_push_pull;
		@(posedge core_clk) disable iff (reset)
		settled && $past(inMode_q[0]) |-> bidirOe_n == $past(modeReg_q) && bidirOut == $past(dataReg_q);
	endproperty
	a_push_pull: assert property (p_push_pull) else $error("push-pull drive wrong");

	property p_open_drain;
		@(posedge core_clk) disable iff (reset)
		settled && !$past(inMode_q[0]) |-> bidirOut == '0 && bidirOe_n == ($past(modeReg_q) | $past(dataReg_q));
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("open-drain drive wrong");

	property p_wake_gates;
		@(posedge core_clk) disable iff (reset)
		settled |-> wakeOrLevel == |$past(bidirIn, 3) && wakeAndLevel == &$past(bidirIn, 3);
	endproperty
	a_wake_gates: assert property (p_wake_gates) else $error("wake gate level wrong");

	property p_timer_bit0;
		@(posedge core_clk) disable iff (reset)
		settled && $past(edgeCfg_q.timerSelBidir && timerDemodMode) |-> timerEdgeIn == $past(bidirIn[0], 3);
	endproperty
	a_timer_bit0: assert property (p_timer_bit0) else $error("timer source not bit 0");

	property p_timer_pin1;
		@(posedge core_clk) disable iff (reset)
		settled && !$past(edgeCfg_q.timerSelBidir) && !$past(cmpEnable, 1) && !$past(cmpEnable, 2)
		|-> timerEdgeIn == $past(inportPin1, 3);
	endproperty
	a_timer_pin1: assert property (p_timer_pin1) else $error("timer source not pin 1");

	property p_cmp_src;
		@(posedge core_clk) disable iff (reset)
		settled && cmpEnable |-> inLvl.pin1 == $past(cmpOut[0], 2) && inLvl.pin2 == $past(cmpOut[1], 2);
	endproperty
	a_cmp_src: assert property (p_cmp_src) else $error("comparator level not used");

	property p_pin1_rise;
		@(posedge core_clk) disable iff (reset || stopRecover)
		settled && edgeCfg_q.pin1Edge == p23io_pkg::EDGE_RISE && $rose(inLvl.pin1)
		|=> irqRequest[0] && status_q[p23io_pkg::ST_PIN1];
	endproperty
	a_pin1_rise: assert property (p_pin1_rise) else $error("pin 1 rise not flagged");

	property p_pin2_fall;
		@(posedge core_clk) disable iff (reset || stopRecover)
		settled && edgeCfg_q.pin2Edge == p23io_pkg::EDGE_FALL && $fell(inLvl.pin2)
		|=> irqRequest[1] && status_q[p23io_pkg::ST_PIN2];
	endproperty
	a_pin2_fall: assert property (p_pin2_fall) else $error("pin 2 fall not flagged");

	property p_mode_keep;
		@(posedge core_clk) disable iff (reset)
		stopRecover && !wrPend_q |=> $stable(modeReg_q) && $stable(inMode_q);
	endproperty
	a_mode_keep: assert property (p_mode_keep) else $error("mode lost on stop recovery");

	property p_sync_delay;
		@(posedge core_clk) disable iff (reset)
		settled |-> bidirLvl == $past(bidirIn, 2);
	endproperty
	a_sync_delay: assert property (p_sync_delay) else $error("pin level not two-flop delayed");

endmodule
`default_nettype wire

//--- sim/p23io_board.sv
// Board model: pin drivers and pull-ups on the port lines
`timescale 1ns/1ns
`default_nettype none

module p23io_board (
	input wire logic [7:0] bidirOut,
	input wire logic [7:0] bidirOe_n,
	input wire logic [7:0] extVal,
	input wire logic [7:0] extEn,
	input wire logic pin1Val,
	input wire logic pin2Val,
	input wire logic [1:0] cmpVal,
	output logic [7:0] bidirIn,
	output logic inportPin1,
	output logic inportPin2,
	output logic [1:0] cmpOut
);
	// open-drain release
	// Device drive wins, then the board; a released line floats up to the pull-up
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (!bidirOe_n[i]) begin
				bidirIn[i] = bidirOut[i];
			end else if (extEn[i]) begin
				bidirIn[i] = extVal[i];
			end else begin
				bidirIn[i] = 1'b1;
			end
		end
	end

	// Input pins and comparator results pass straight through
	assign inportPin1 = pin1Val;
	assign inportPin2 = pin2Val;
	assign cmpOut = cmpVal;
endmodule

`default_nettype wire

//--- sim/port2_port3_io_logic_tb.sv
// Testbench for the port logic: bus tasks, board stimulus and checks
`timescale 1ns/1ns
`default_nettype none

module port2_port3_io_logic_tb;
	logic core_clk, reset, stopRecover, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans, cmpVal, cmpOut, irqRequest;
	logic [2:0] hsize;
	logic [7:0] bidirIn, bidirOut, bidirOe_n, extVal, extEn;
	logic inportPin1, inportPin2, pin1Val, pin2Val, cmpEnable, timerDemodMode;
	logic timerEdgeIn, wakeOrLevel, wakeAndLevel, wakeRequest, irqOut;
	int nFail = 0;
	int checkCount = 0;
	int irqCnt [2];
	int expCnt [4] = '{0, 1, 1, 2};
	logic [7:0] vals [3] = '{8'h00, 8'h5A, 8'hFF};

	// Single slave, so its ready is the bus ready
	assign hready = hreadyout;

	p23io_port p23io_port_inst (.core_clk, .reset, .stopRecover, .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .bidirIn, .bidirOut,
		.bidirOe_n, .inportPin1, .inportPin2, .cmpOut, .cmpEnable, .timerDemodMode,
		.timerEdgeIn, .wakeOrLevel, .wakeAndLevel, .wakeRequest, .irqRequest, .irqOut);

	p23io_board p23io_board_inst (.bidirOut, .bidirOe_n, .extVal, .extEn, .pin1Val,
		.pin2Val, .cmpVal, .bidirIn, .inportPin1, .inportPin2, .cmpOut);

	// 125 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	// Count request pulses mid-cycle, away from the launching edge
	always @(negedge core_clk) begin
		for (int i = 0; i < 2; i++) begin
			if (irqRequest[i] === 1'b1) begin
				irqCnt[i]++;
			end
		end
	end

	task automatic stop_test();
		$display("Checks %0d mismatches %0d", checkCount, nFail);
		if (nFail == 0 && checkCount > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checkCount++;
		if (got !== exp) begin
			nFail++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Sample before the edge so the edge's own updates never race the check
	task automatic waitReady(output logic [31:0] data);
		logic rdy;
		rdy = 1'b0;
		for (int i = 0; i < 20 && !rdy; i++) begin
			@(negedge core_clk);
			rdy = hreadyout;
			data = hrdata;
			@(posedge core_clk);
		end
		if (!rdy) begin
			nFail++;
			stop_test();
		end
	endtask

	// One single-word transfer: address phase, then data phase
	task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
		output logic [31:0] data);
		@(posedge core_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h000000, ofs};
		waitReady(data);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		waitReady(data);
	endtask

	task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, ofs, d, x);
	endtask

	task automatic rdc(input string what, input logic [7:0] ofs, input logic [31:0] e);
		logic [31:0] x;
		bus(1'b0, ofs, 32'h00000000, x);
		chk(what, e, x);
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	initial begin
		reset <= 1'b1;
		stopRecover <= 1'b0;
		hsel <= 1'b0;
		haddr <= 32'h00000000;
		htrans <= 2'h0;
		hwrite <= 1'b0;
		hsize <= 3'h2;
		hwdata <= 32'h00000000;
		extVal <= 8'h03;
		extEn <= 8'h0F;
		pin1Val <= 1'b0;
		pin2Val <= 1'b0;
		cmpVal <= 2'h0;
		timerDemodMode <= 1'b0;
		repeat (8) @(posedge core_clk);
		reset <= 1'b0;
		settle(1);
		// Reset state: all lines inputs, nothing driven
		chk("oe_n", 32'hFF, 32'(bidirOe_n));
		chk("hresp", 32'h0, 32'(hresp));
		chk("irqOut", 32'h0, 32'(irqOut));
		rdc("bidirMode", p23io_pkg::OFS_BIDIR_MODE, 32'hFF);
		rdc("inportMode", p23io_pkg::OFS_INPORT_MODE, 32'h0);
		rdc("unmapped", 8'h20, 32'h0);
		// Upper nibble outputs in push-pull, then open-drain
		wr(p23io_pkg::OFS_DATA, 32'hA5);
		wr(p23io_pkg::OFS_INPORT_MODE, 32'h1);
		wr(p23io_pkg::OFS_BIDIR_MODE, 32'h0F);
		settle(4);
		chk("oe_n pp", 32'h0F, 32'(bidirOe_n));
		chk("out pp", 32'hA0, 32'(bidirOut & 8'hF0));
		rdc("lvl pp", p23io_pkg::OFS_DATA, 32'hA3);
		wr(p23io_pkg::OFS_INPORT_MODE, 32'h0);
		settle(4);
		chk("oe_n od", 32'hAF, 32'(bidirOe_n));
		chk("out od", 32'h0, 32'(bidirOut));
		rdc("lvl od", p23io_pkg::OFS_DATA, 32'hA3);
		// Wake gates over all eight inputs, AND selected
		wr(p23io_pkg::OFS_BIDIR_MODE, 32'hFF);
		wr(p23io_pkg::OFS_INT_CLEAR, 32'h7);
		wr(p23io_pkg::OFS_EDGE_CFG, 32'h60);
		for (int k = 0; k < 3; k++) begin
			@(posedge core_clk);
			extEn <= 8'hFF;
			extVal <= vals[k];
			settle(4);
			chk("wakeOr", 32'(vals[k] != 8'h00), 32'(wakeOrLevel));
			chk("wakeAnd", 32'(vals[k] == 8'hFF), 32'(wakeAndLevel));
			chk("wakeReq", 32'(vals[k] == 8'hFF), 32'(wakeRequest));
		end
		rdc("wake st", p23io_pkg::OFS_INT_STATUS, 32'h4);
		// Timer source: port bit 0 in demodulation, pin 1 otherwise
		wr(p23io_pkg::OFS_EDGE_CFG, 32'h10);
		@(posedge core_clk);
		timerDemodMode <= 1'b1;
		extVal <= 8'hFE;
		settle(4);
		chk("tmr bit0", 32'h0, 32'(timerEdgeIn));
		@(posedge core_clk);
		extVal <= 8'h01;
		settle(4);
		chk("tmr bit0", 32'h1, 32'(timerEdgeIn));
		@(posedge core_clk);
		timerDemodMode <= 1'b0;
		extVal <= 8'h00;
		pin1Val <= 1'b1;
		settle(4);
		chk("tmr pin1", 32'h1, 32'(timerEdgeIn));
		@(posedge core_clk);
		pin1Val <= 1'b0;
		settle(4);
		chk("tmr pin1", 32'h0, 32'(timerEdgeIn));
		// Comparators take over the pin levels when enabled
		wr(p23io_pkg::OFS_INPORT_MODE, 32'h2);
		@(posedge core_clk);
		cmpVal <= 2'h2;
		settle(4);
		chk("cmpEnable", 32'h1, 32'(cmpEnable));
		rdc("lvl cmp", p23io_pkg::OFS_LEVELS, 32'hA);
		wr(p23io_pkg::OFS_INPORT_MODE, 32'h0);
		wr(p23io_pkg::OFS_INT_ENABLE, 32'h3);
		// Every trigger mode on both pins: one rise and one fall each
		for (int m = 0; m < 4; m++) begin
			wr(p23io_pkg::OFS_EDGE_CFG, 32'(m * 5));
			wr(p23io_pkg::OFS_INT_CLEAR, 32'h7);
			irqCnt[0] = 0;
			irqCnt[1] = 0;
			@(posedge core_clk);
			pin1Val <= 1'b1;
			pin2Val <= 1'b1;
			settle(6);
			@(posedge core_clk);
			pin1Val <= 1'b0;
			pin2Val <= 1'b0;
			settle(6);
			chk("irq1 cnt", 32'(expCnt[m]), 32'(irqCnt[0]));
			chk("irq2 cnt", 32'(expCnt[m]), 32'(irqCnt[1]));
			chk("irqOut", 32'(m != 0), 32'(irqOut));
			rdc("status", p23io_pkg::OFS_INT_STATUS, (m != 0) ? 32'h3 : 32'h0);
		end
		wr(p23io_pkg::OFS_INT_CLEAR, 32'h1);
		rdc("st clr", p23io_pkg::OFS_INT_STATUS, 32'h2);
		wr(p23io_pkg::OFS_INT_ENABLE, 32'h1);
		settle(1);
		chk("irq mask", 32'h0, 32'(irqOut));
		// Stop-mode recovery keeps both mode registers only
		wr(p23io_pkg::OFS_BIDIR_MODE, 32'h3C);
		wr(p23io_pkg::OFS_INPORT_MODE, 32'h1);
		wr(p23io_pkg::OFS_EDGE_CFG, 32'h15);
		@(posedge core_clk);
		stopRecover <= 1'b1;
		@(posedge core_clk);
		stopRecover <= 1'b0;
		rdc("bidir kept", p23io_pkg::OFS_BIDIR_MODE, 32'h3C);
		rdc("inport kept", p23io_pkg::OFS_INPORT_MODE, 32'h1);
		rdc("cfg clr", p23io_pkg::OFS_EDGE_CFG, 32'h0);
		stop_test();
	end
endmodule

`default_nettype wire
